// >>> logic/output_clock_freeze_control.sv
/*
  freeze control for a fifteen-output clock generator: waveform
  generation, serial mask receiver, common strobe, per-output gating.
  assumes ref_clk at 50 MHz, a free-running serial clock from the
  host, and strobe, level and ratio pins asynchronous to ref_clk.
*/
// Overview of operation
// - thirteen-bit serial mask, one bit per output
// - base bus and peripheral clocks lack mask
// - zero freezes an output, one lets it run
// - frozen outputs rest low, never high
// - strobe pulse freezes or releases all fifteen
// - freeze waits for the natural falling edge
// - release only while the clock is low
// - one bit per serial clock, rising-edge sampled
// - bits 0-2: double rate, cpu enable, bus enable
// - bits 3-6: bus clocks one to four
// - bits 7-12: peripheral clocks one to six
// - cpu enable runs at half double rate
// - bus enable at 1, 1/2, 1/3, 1/4 rate
module output_clock_freeze_control (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic frz_clk,
  input wire logic frz_data,
  input wire logic frz_strobe_n,
  input wire logic com_frz_level,
  input wire logic [1:0] bus_ratio_sel,
  output logic double_rate_cpu_clock,
  output logic cpu_clock_enable,
  output logic bus_clock_enable_out,
  output logic bus_clock_base,
  output logic periph_clock_base,
  output logic [3:0] bus_clocks_one_to_four,
  output logic [5:0] periph_clocks_one_to_six,
  output logic [14:0] run_state
);

  // link domain: reset and enable brought over from ref_clk
  logic link_rst_meta; // first stage, read by second only
  logic link_rst; // synchronised reset for the link side
  logic link_ce_meta; // first stage, read by second only
  logic link_ce; // synchronised clock enable

  // link domain: serial receiver
  freeze_pkg::rx_state_t rx_state_reg; // idle or collecting bits
  logic [3:0] bit_cnt_reg; // index of the next mask bit
  logic [12:0] freeze_mask_shift_reg; // bits arrive lsb first
  logic [12:0] frame_word_reg; // completed frame, held stable
  logic done_tgl_reg; // flips once per completed frame

  // ref domain: crossing of the frame event
  logic done_meta; // first stage, read by second only
  logic done_sync; // synchronised toggle
  logic done_seen_reg; // toggle value already consumed
  logic frame_event; // one cycle per received frame
  logic frame_apply_reg; // mask word copied, apply it now

  // ref domain: pin synchronisers
  freeze_pkg::pin_sample_t pin_raw; // pins bundled as sampled
  freeze_pkg::pin_sample_t pin_meta; // first stage, read once
  freeze_pkg::pin_sample_t pin_sync; // safe to use
  logic strobe_prev_reg; // strobe one cycle ago
  logic strobe_release; // strobe went from low to high

  // ref domain: freeze state
  logic [12:0] mask_word_reg; // last mask taken from the link
  logic [14:0] run_reg; // per-output run request
  logic [14:0] run_next;

  // ref domain: waveform generation
  logic [1:0] cpu_phase_reg; // position in one cpu period
  logic [3:0] bus_phase_reg; // position in one bus period
  logic [1:0] ratio_reg; // ratio in force this bus period
  logic bus_wrap; // last cycle of the bus period
  freeze_pkg::clock_vec_t raw_reg; // ungated waveforms
  freeze_pkg::clock_vec_t gated; // gated outputs, from flops
  logic [14:0] raw_bits; // raw waveforms as a vector
  logic [14:0] gated_bits; // gated waveforms as a vector

  // reset and enable into the serial clock domain; the serial clock
  // runs free, so a plain two-stage crossing suffices
  always_ff @(posedge frz_clk) begin
    link_rst_meta <= reset;
    link_rst <= link_rst_meta;
    link_ce_meta <= ce;
    link_ce <= link_ce_meta;
  end

  // receiver state: a low bit while idle opens a frame
  always_ff @(posedge frz_clk) begin
    if (link_rst) begin
      rx_state_reg <= freeze_pkg::RX_IDLE;
    end else if (link_ce) begin
      unique case (rx_state_reg)
        freeze_pkg::RX_IDLE: begin
          // high line is idle and ignored
          if (!frz_data) begin
            rx_state_reg <= freeze_pkg::RX_DATA;
          end
        end
        freeze_pkg::RX_DATA: begin
          // the thirteenth bit ends the frame
          if (bit_cnt_reg == freeze_pkg::LAST_BIT_IDX) begin
            rx_state_reg <= freeze_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // bit counter, restarted by every start bit
  always_ff @(posedge frz_clk) begin
    if (link_rst) begin
      bit_cnt_reg <= freeze_pkg::FIRST_BIT_IDX;
    end else if (link_ce) begin
      if (rx_state_reg == freeze_pkg::RX_IDLE) begin
        bit_cnt_reg <= freeze_pkg::FIRST_BIT_IDX;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // shifter: one bit per rising serial edge, bit 0 first, so after
  // thirteen shifts bit 0 sits at the bottom
  always_ff @(posedge frz_clk) begin
    if (link_rst) begin
      freeze_mask_shift_reg <= freeze_pkg::MASK_RESET;
    end else if (link_ce) begin
      if (rx_state_reg == freeze_pkg::RX_DATA) begin
        freeze_mask_shift_reg <= {frz_data, freeze_mask_shift_reg[12:1]};
      end
    end
  end

  // completed frame: word held until the next frame ends, so the
  // ref side may read it after the toggle has crossed
  always_ff @(posedge frz_clk) begin
    if (link_rst) begin
      frame_word_reg <= freeze_pkg::MASK_RESET;
      done_tgl_reg <= 1'b0;
    end else if (link_ce) begin
      if (rx_state_reg == freeze_pkg::RX_DATA &&
          bit_cnt_reg == freeze_pkg::LAST_BIT_IDX) begin
        frame_word_reg <= {frz_data, freeze_mask_shift_reg[12:1]};
        done_tgl_reg <= ~done_tgl_reg;
      end
    end
  end

  // frame toggle into ref_clk
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
    end else if (ce) begin
      done_meta <= done_tgl_reg;
      done_sync <= done_meta;
    end
  end

  // edge of the synchronised toggle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_seen_reg <= 1'b0;
    end else if (ce) begin
      done_seen_reg <= done_sync;
    end
  end

  assign frame_event = done_sync ^ done_seen_reg;

  // mask copy; the link word is stable by the time the event arrives
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_word_reg <= freeze_pkg::MASK_RESET;
    end else if (ce && frame_event) begin
      mask_word_reg <= frame_word_reg;
    end
  end

  // apply one cycle after the copy, so run requests are taken from
  // the ref-side mask word and never straight off the link register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_apply_reg <= 1'b0;
    end else if (ce) begin
      frame_apply_reg <= frame_event;
    end
  end

  // strobe, level and ratio pins sampled twice before use
  assign pin_raw = '{strobe_n: frz_strobe_n, level: com_frz_level,
                     ratio: bus_ratio_sel};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_meta <= '{strobe_n: 1'b1, level: 1'b1,
                    ratio: freeze_pkg::RATIO_RESET};
      pin_sync <= '{strobe_n: 1'b1, level: 1'b1,
                    ratio: freeze_pkg::RATIO_RESET};
    end else if (ce) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // strobe history for the end-of-pulse edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strobe_prev_reg <= 1'b1;
    end else if (ce) begin
      strobe_prev_reg <= pin_sync.strobe_n;
    end
  end

  // the level is taken as the low pulse ends; it was sampled in the
  // same stage, so a level set up before the pulse is always seen
  assign strobe_release = pin_sync.strobe_n & ~strobe_prev_reg;

  // run requests: mask reaches thirteen outputs, strobe all fifteen;
  // when both land in one cycle the strobe wins
  always_comb begin
    run_next = run_reg;
    if (frame_apply_reg) begin
      // zero freezes, one runs
      run_next[12:0] = mask_word_reg;
      // base outputs keep their state on a mask load
      run_next[freeze_pkg::IDX_BUS_BASE] =
        run_reg[freeze_pkg::IDX_BUS_BASE];
      run_next[freeze_pkg::IDX_PERIPH_BASE] =
        run_reg[freeze_pkg::IDX_PERIPH_BASE];
    end
    if (strobe_release) begin
      run_next = {freeze_pkg::NUM_OUTPUTS{pin_sync.level}};
    end
  end

  // run state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_reg <= freeze_pkg::RUN_RESET;
    end else if (ce) begin
      run_reg <= run_next;
    end
  end

  // cpu phase: four reference cycles per cpu clock period
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cpu_phase_reg <= freeze_pkg::CPU_PHASE_RESET;
    end else if (ce) begin
      cpu_phase_reg <= cpu_phase_reg + 2'h1;
    end
  end

  assign bus_wrap = bus_phase_reg == freeze_pkg::bus_period_last(ratio_reg);

  // bus phase, always a whole number of cpu periods, so the slow
  // clocks stay aligned to the cpu enable
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_phase_reg <= freeze_pkg::BUS_PHASE_RESET;
    end else if (ce) begin
      if (bus_wrap) begin
        bus_phase_reg <= freeze_pkg::BUS_PHASE_RESET;
      end else begin
        bus_phase_reg <= bus_phase_reg + 4'h1;
      end
    end
  end

  // ratio changes only at a period boundary, never mid-pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ratio_reg <= freeze_pkg::RATIO_RESET;
    end else if (ce && bus_wrap) begin
      ratio_reg <= pin_sync.ratio;
    end
  end

  // raw waveforms, registered so the gates see clean levels
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      raw_reg <= '0;
    end else if (ce) begin
      raw_reg.dbl <= ~cpu_phase_reg[0];
      raw_reg.cpu_en <= ~cpu_phase_reg[1];
      // duty set by the ratio decode
      raw_reg.bus_en <=
        bus_phase_reg < freeze_pkg::bus_en_high(ratio_reg);
      raw_reg.bus <= {4{bus_phase_reg <
        freeze_pkg::bus_clk_high(ratio_reg)}};
      raw_reg.periph <= {6{bus_phase_reg <
        freeze_pkg::bus_clk_high(ratio_reg)}};
      raw_reg.bus_base <=
        bus_phase_reg < freeze_pkg::bus_clk_high(ratio_reg);
      raw_reg.periph_base <=
        bus_phase_reg < freeze_pkg::bus_clk_high(ratio_reg);
    end
  end

  assign raw_bits = raw_reg;

  // one gating cell per output clock
  genvar gi;
  generate
    for (gi = 0; gi < freeze_pkg::NUM_OUTPUTS; gi++) begin : g_gate
      glitch_free_gate u_gate (
        .ref_clk(ref_clk),
        .reset(reset),
        .ce(ce),
        .raw_clk(raw_bits[gi]),
        .run_req(run_reg[gi]),
        .gated_clk(gated_bits[gi])
      );
    end
  endgenerate

  assign gated = gated_bits;

  // clock ports come straight from the gate flops, run_state from run_reg
  assign double_rate_cpu_clock = gated.dbl;
  assign cpu_clock_enable = gated.cpu_en;
  assign bus_clock_enable_out = gated.bus_en;
  assign bus_clock_base = gated.bus_base;
  assign periph_clock_base = gated.periph_base;
  assign bus_clocks_one_to_four = gated.bus;
  assign periph_clocks_one_to_six = gated.periph;
  assign run_state = run_reg;

endmodule

// >>> logic/freeze_pkg.sv
/*
  constants, types and ratio decoders shared by the freeze control
  block and its glitch-free gating cell.
  assumes a 50 MHz reference clock and a free-running serial clock.
*/
package freeze_pkg;

  // widths of the mask and of the output set
  localparam int MASK_WIDTH = 13;
  localparam int NUM_OUTPUTS = 15;

  // serial frame: start bit then bits 0..12
  localparam logic [3:0] LAST_BIT_IDX = 4'hc;
  localparam logic [3:0] FIRST_BIT_IDX = 4'h0;

  // values after reset: everything running
  localparam logic [12:0] MASK_RESET = 13'h1fff;
  localparam logic [14:0] RUN_RESET = 15'h7fff;
  localparam logic [1:0] RATIO_RESET = 2'h0;
  localparam logic [1:0] CPU_PHASE_RESET = 2'h0;
  localparam logic [3:0] BUS_PHASE_RESET = 4'h0;
  localparam logic GATE_ACTIVE_RESET = 1'b1;

  // output positions in the mask and run vectors
  localparam int IDX_DBL = 0;
  localparam int IDX_CPU_EN = 1;
  localparam int IDX_BUS_EN = 2;
  localparam int IDX_BUS_FIRST = 3;
  localparam int IDX_PERIPH_FIRST = 7;
  localparam int IDX_BUS_BASE = 13;
  localparam int IDX_PERIPH_BASE = 14;

  // bus enable rate relative to the cpu clock
  localparam logic [1:0] RATIO_ONE = 2'h0;
  localparam logic [1:0] RATIO_HALF = 2'h1;
  localparam logic [1:0] RATIO_THIRD = 2'h2;
  localparam logic [1:0] RATIO_QUARTER = 2'h3;

  // reference cycles per cpu clock period (double rate is half)
  localparam int REF_PER_CPU = 4;

  // last phase of one bus period, in reference cycles
  function automatic logic [3:0] bus_period_last(input logic [1:0] sel);
    unique case (sel)
      RATIO_ONE: bus_period_last = 4'h3;
      RATIO_HALF: bus_period_last = 4'h7;
      RATIO_THIRD: bus_period_last = 4'hb;
      RATIO_QUARTER: bus_period_last = 4'hf;
    endcase
  endfunction

  // high time of the bus enable: 66/33 and 75/25 at slow rates
  function automatic logic [3:0] bus_en_high(input logic [1:0] sel);
    unique case (sel)
      RATIO_ONE: bus_en_high = 4'h2;
      RATIO_HALF: bus_en_high = 4'h4;
      RATIO_THIRD: bus_en_high = 4'h8;
      RATIO_QUARTER: bus_en_high = 4'hc;
    endcase
  endfunction

  // high time of bus and peripheral clocks: square wave
  function automatic logic [3:0] bus_clk_high(input logic [1:0] sel);
    unique case (sel)
      RATIO_ONE: bus_clk_high = 4'h2;
      RATIO_HALF: bus_clk_high = 4'h4;
      RATIO_THIRD: bus_clk_high = 4'h6;
      RATIO_QUARTER: bus_clk_high = 4'h8;
    endcase
  endfunction

  // output clocks in mask bit order, bit 0 last
  typedef struct packed {
    logic periph_base;
    logic bus_base;
    logic [5:0] periph;
    logic [3:0] bus;
    logic bus_en;
    logic cpu_en;
    logic dbl;
  } clock_vec_t;

  // asynchronous control pins sampled together
  typedef struct packed {
    logic strobe_n;
    logic level;
    logic [1:0] ratio;
  } pin_sample_t;

  // serial receiver states
  typedef enum logic {RX_IDLE, RX_DATA} rx_state_t;

endpackage

// >>> logic/glitch_free_gate.sv
/*
  one glitch-free gating cell for a single output clock.
  assumes raw_clk is a registered waveform on ref_clk and run_req
  is a level on the same clock.
*/
module glitch_free_gate (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic raw_clk,
  input wire logic run_req,
  output logic gated_clk
);

  logic active_reg; // gate state, only moves while raw is low
  logic active_next;

  // the gate may change only while the clock sits low, so a freeze
  // waits for the natural fall and a release never cuts a high half
  always_comb begin
    active_next = raw_clk ? active_reg : run_req;
  end

  // gate state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_reg <= freeze_pkg::GATE_ACTIVE_RESET;
    end else if (ce) begin
      active_reg <= active_next;
    end
  end

  // output flop: a closed gate parks the clock at low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gated_clk <= 1'b0;
    end else if (ce) begin
      gated_clk <= raw_clk & active_next;
    end
  end

endmodule

// >>> test/freeze_ctl_sva.sv
/*
  concurrent checks on the ports of the freeze control block.
  assumes one ref_clk domain, synchronous active-high reset, ce high.
*/
module freeze_ctl_sva (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic frz_strobe_n,
  input wire logic com_frz_level,
  input wire logic [1:0] bus_ratio_sel,
  input wire logic double_rate_cpu_clock,
  input wire logic cpu_clock_enable,
  input wire logic bus_clock_enable_out,
  input wire logic bus_clock_base,
  input wire logic periph_clock_base,
  input wire logic [3:0] bus_clocks_one_to_four,
  input wire logic [5:0] periph_clocks_one_to_six,
  input wire logic [14:0] run_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [14:0] all_outs; // outputs in mask order
  logic strb_reg; // strobe one sample back
  logic lvl_reg; // level seen at strobe release
  logic [4:0] hi_reg; // high run of the bus enable
  logic [1:0] sel_reg; // ratio pin one sample back
  logic [4:0] age_reg; // cycles since the ratio pin moved
  logic [5:0] quiet_reg; // cycles with every run bit clear
  logic [4:0] hi_exp; // expected bus enable high time
  assign all_outs = {periph_clock_base, bus_clock_base,
    periph_clocks_one_to_six, bus_clocks_one_to_four,
    bus_clock_enable_out, cpu_clock_enable, double_rate_cpu_clock};
  assign hi_exp = (sel_reg == 2'h0) ? 5'h2 : (sel_reg == 2'h1) ? 5'h4 :
    (sel_reg == 2'h2) ? 5'h8 : 5'hc;
  // level is taken where the strobe pulse ends
  always_ff @(posedge ref_clk) begin
    strb_reg <= frz_strobe_n;
    if (frz_strobe_n && !strb_reg) begin
      lvl_reg <= com_frz_level;
    end
  end
  // high length counter, cleared while low
  always_ff @(posedge ref_clk) begin
    hi_reg <= bus_clock_enable_out ? hi_reg + 5'h1 : 5'h0;
  end
  // ratio age saturates so a stale period is never judged
  always_ff @(posedge ref_clk) begin
    sel_reg <= bus_ratio_sel;
    if (reset || sel_reg != bus_ratio_sel) begin
      age_reg <= 5'h0;
    end else if (age_reg != 5'h1f) begin
      age_reg <= age_reg + 5'h1;
    end
  end
  // all-frozen duration, saturating
  always_ff @(posedge ref_clk) begin
    if (reset || run_state != 15'h0) begin
      quiet_reg <= 6'h0;
    end else if (quiet_reg != 6'h3f) begin
      quiet_reg <= quiet_reg + 6'h1;
    end
  end
  sequence cpu_hold_s;
    cpu_clock_enable ##1 !cpu_clock_enable;
  endsequence
  sequence strobe_done_s;
    ##[3:5] run_state == {15{lvl_reg}};
  endsequence
  reset_vals_a: assert property ($fell(reset) |->
    run_state == 15'h7fff && all_outs == 15'h0)
    else $error("state after reset wrong");
  dbl_pulse_a: assert property ($rose(double_rate_cpu_clock) |=>
    !double_rate_cpu_clock) else $error("double rate high too long");
  cpu_half_a: assert property ($rose(cpu_clock_enable) |=>
    cpu_hold_s) else $error("cpu enable not half rate");
  bus_duty_a: assert property ($fell(bus_clock_enable_out) &&
    age_reg == 5'h1f |-> hi_reg == hi_exp)
    else $error("bus enable high time wrong");
  base_whole_a: assert property ($changed(run_state[14:13]) |->
    run_state == {15{run_state[13]}}) else $error("base run bit moved");
  strobe_apply_a: assert property ($rose(frz_strobe_n) |->
    strobe_done_s) else $error("strobe not applied");
  no_early_rise_a: assert property ($rose(double_rate_cpu_clock) |->
    run_state[0] || $past(run_state[0], 4))
    else $error("frozen clock rose");
  frozen_low_a: assert property (!run_state[0] [*6] |->
    !double_rate_cpu_clock) else $error("frozen clock not low");
  all_quiet_a: assert property (quiet_reg >= 6'h18 |->
    all_outs == 15'h0) else $error("outputs run while frozen");
endmodule

bind output_clock_freeze_control freeze_ctl_sva u_freeze_ctl_sva (
  .ref_clk(ref_clk),
  .reset(reset),
  .frz_strobe_n(frz_strobe_n),
  .com_frz_level(com_frz_level),
  .bus_ratio_sel(bus_ratio_sel),
  .double_rate_cpu_clock(double_rate_cpu_clock),
  .cpu_clock_enable(cpu_clock_enable),
  .bus_clock_enable_out(bus_clock_enable_out),
  .bus_clock_base(bus_clock_base),
  .periph_clock_base(periph_clock_base),
  .bus_clocks_one_to_four(bus_clocks_one_to_four),
  .periph_clocks_one_to_six(periph_clocks_one_to_six),
  .run_state(run_state)
);

// >>> test/frz_host_model.sv
/*
  host side of the serial freeze port: start bit, thirteen mask bits
  with bit 0 first, then the line idles high.
  assumes a free-running serial clock and a toggling request.
*/
module frz_host_model (
  input wire logic frz_clk,
  input wire logic send_req,
  input wire logic [12:0] mask_val,
  output logic frz_data,
  output logic host_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack_reg = 1'b0; // last request served
  logic [12:0] shift_reg = 13'h1fff; // bits yet to go out
  logic [3:0] left_reg = 4'h0; // count of bits yet to go out
  initial frz_data = 1'b1;
  assign host_busy = (send_req != ack_reg) || (left_reg != 4'h0);
  // falling-edge launch keeps each bit settled at the sampling rise
  always @(negedge frz_clk) begin
    if (left_reg != 4'h0) begin
      frz_data <= shift_reg[0];
      shift_reg <= shift_reg >> 1;
      left_reg <= left_reg - 4'h1;
    end else if (send_req != ack_reg) begin
      frz_data <= 1'b0;
      shift_reg <= mask_val;
      left_reg <= 4'hd;
      ack_reg <= send_req;
    end else begin
      frz_data <= 1'b1;
    end
  end
endmodule

// >>> test/tb_top.sv
/*
  self-checking bench for the freeze control block.
  assumes the host model on the serial port and the bound checker.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0; // main clock
  logic frz_clk = 1'b0; // serial clock, free running
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic frz_data; // from the host model
  logic frz_strobe_n = 1'b1;
  logic com_frz_level = 1'b1;
  logic [1:0] bus_ratio_sel = 2'h0;
  logic send_req = 1'b0; // toggles to ask for a frame
  logic [12:0] mask_val = 13'h1fff;
  logic host_busy;
  logic double_rate_cpu_clock, cpu_clock_enable, bus_clock_enable_out;
  logic bus_clock_base, periph_clock_base;
  logic [3:0] bus_clocks_one_to_four;
  logic [5:0] periph_clocks_one_to_six;
  logic [14:0] run_state;
  freeze_pkg::clock_vec_t outs; // outputs in mask order
  int miscompares = 0;
  int samples_checked = 0;
  assign outs = {periph_clock_base, bus_clock_base,
    periph_clocks_one_to_six, bus_clocks_one_to_four,
    bus_clock_enable_out, cpu_clock_enable, double_rate_cpu_clock};
  output_clock_freeze_control u_output_clock_freeze_control (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .frz_clk(frz_clk),
    .frz_data(frz_data), .frz_strobe_n(frz_strobe_n),
    .com_frz_level(com_frz_level), .bus_ratio_sel(bus_ratio_sel),
    .double_rate_cpu_clock(double_rate_cpu_clock),
    .cpu_clock_enable(cpu_clock_enable),
    .bus_clock_enable_out(bus_clock_enable_out),
    .bus_clock_base(bus_clock_base),
    .periph_clock_base(periph_clock_base),
    .bus_clocks_one_to_four(bus_clocks_one_to_four),
    .periph_clocks_one_to_six(periph_clocks_one_to_six),
    .run_state(run_state));
  frz_host_model u_frz_host_model (
    .frz_clk(frz_clk), .send_req(send_req), .mask_val(mask_val),
    .frz_data(frz_data), .host_busy(host_busy));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // odd start offset keeps the two clocks apart in phase
  initial begin
    #3;
    forever #15 frz_clk = ~frz_clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp_vec(input logic [14:0] got, input logic [14:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: vector %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      miscompares++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  // collects every output that went high over n cycles
  task automatic observe(input int n, output logic [14:0] seen);
    seen = 15'h0;
    repeat (n) begin
      @(negedge ref_clk);
      seen = seen | outs;
    end
  endtask
  task automatic send_mask(input logic [12:0] m);
    int n;
    n = 0;
    @(negedge ref_clk);
    mask_val = m;
    send_req = ~send_req;
    @(negedge ref_clk);
    while (host_busy && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    cmp_vec({14'h0, host_busy}, 15'h0);
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic pulse_strobe(input logic lvl);
    @(negedge ref_clk);
    com_frz_level = lvl;
    repeat (2) @(negedge ref_clk);
    frz_strobe_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    frz_strobe_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic high_len(input int idx, output int h);
    int n;
    n = 0;
    h = 0;
    while (outs[idx] !== 1'b0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    while (outs[idx] !== 1'b1 && n < 80) begin
      @(negedge ref_clk);
      n++;
    end
    while (outs[idx] === 1'b1 && h < 40) begin
      @(negedge ref_clk);
      h++;
    end
  endtask
  task automatic t_masks;
    logic [14:0] seen;
    logic [12:0] m;
    observe(40, seen);
    cmp_vec(seen, 15'h7fff);
    for (int i = 0; i < 13; i++) begin
      m = ~(13'h1 << i);
      send_mask(m);
      cmp_vec(run_state, {2'h3, m});
      repeat (24) @(negedge ref_clk);
      observe(40, seen);
      cmp_vec(seen, {2'h3, m});
    end
  endtask
  task automatic t_strobe;
    logic [14:0] seen;
    send_mask(13'h0);
    cmp_vec(run_state, 15'h6000);
    repeat (24) @(negedge ref_clk);
    observe(40, seen);
    cmp_vec(seen, 15'h6000);
    pulse_strobe(1'b1);
    cmp_vec(run_state, 15'h7fff);
    observe(40, seen);
    cmp_vec(seen, 15'h7fff);
    pulse_strobe(1'b0);
    cmp_vec(run_state, 15'h0);
    repeat (30) @(negedge ref_clk);
    observe(40, seen);
    cmp_vec(seen, 15'h0);
    pulse_strobe(1'b1);
    repeat (60) @(negedge ref_clk);
    cmp_vec(run_state, 15'h7fff);
  endtask
  task automatic t_cpu_rate;
    int d;
    int c;
    logic [14:0] prev;
    d = 0;
    c = 0;
    prev = outs;
    repeat (48) begin
      @(negedge ref_clk);
      if (outs[0] && !prev[0]) d++;
      if (outs[1] && !prev[1]) c++;
      prev = outs;
    end
    cmp_cnt(d, 24);
    cmp_cnt(c, 12);
  endtask
  task automatic t_ratio;
    int hi_exp [4] = '{2, 4, 8, 12};
    int base_exp [4] = '{2, 4, 6, 8};
    int h;
    for (int r = 0; r < 4; r++) begin
      @(negedge ref_clk);
      bus_ratio_sel = 2'(r);
      repeat (40) @(negedge ref_clk);
      high_len(2, h);
      cmp_cnt(h, hi_exp[r]);
      high_len(13, h);
      cmp_cnt(h, base_exp[r]);
    end
  endtask
  // hang guard: the tests need under a fifth of this
  initial begin
    #400us;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    cmp_vec(run_state, 15'h7fff);
    repeat (10) @(negedge ref_clk);
    t_masks();
    t_strobe();
    t_cpu_rate();
    t_ratio();
    conclude();
  end
endmodule
